// ### hw/lhd_pkg.sv
// Purpose: shared constants, types and helpers of the lcd host data interface
// Assumes: one hclk domain, link pins sampled by synchronisers
// Notes:   command encodings and register offsets are local to this block
package lhd_pkg;

  // data processing modes
  typedef enum logic [2:0] {
    MODE_WRITE  = 3'h0,
    MODE_AND    = 3'h1,
    MODE_OR     = 3'h2,
    MODE_READ   = 3'h3,
    MODE_CHAR_L = 3'h4,
    MODE_CHAR_R = 3'h5
  } lhd_mode_e;

  // pointer step after each byte access
  typedef enum logic [1:0] {
    STEP_HOLD = 2'h0,
    STEP_INC  = 2'h1,
    STEP_DEC  = 2'h2
  } lhd_step_e;

  // processing engine states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_EXEC  = 4'h2,
    ST_CHAR  = 4'h4,
    ST_FETCH = 4'h8
  } lhd_state_e;

  // data pointer: bank flag plus word address counter
  typedef struct packed {
    logic       bank_select_flag;
    logic [5:0] word_address_counter;
  } lhd_ptr_s;

  // link pins travelling together through the synchroniser
  typedef struct packed {
    logic       chip_select_n;
    logic       host_strobe;
    logic       command_data_select;
    logic       serial_in;
    logic [3:0] data;
    logic       lcd_reset;
    logic       interface_select;
  } lhd_pins_s;

  localparam lhd_pins_s PINS_RESET = '{1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0};

  // command byte layout
  localparam int unsigned LOAD_BIT   = 7;
  localparam int unsigned BANK_BIT   = 6;
  localparam logic [2:0]  OPC_MODE   = 3'h0;
  localparam logic [2:0]  OPC_CURS_W = 3'h1;
  localparam logic [2:0]  OPC_CURS_C = 3'h2;

  // memory and character geometry
  localparam logic [5:0]  MEM_WORDS  = 6'h32;
  localparam int unsigned CURSOR_BIT = 7;
  localparam int unsigned PAT_W      = 7;
  localparam int unsigned ROM_DEPTH  = 160;
  localparam logic [2:0]  COL_LAST   = 3'h4;
  localparam logic [5:0]  CHAR_STEP  = 6'h05;
  localparam logic [5:0]  UNIT_STEP  = 6'h01;
  localparam logic [7:0]  ASCII_LO   = 8'h20;
  localparam logic [7:0]  ASCII_HI   = 8'h7f;
  localparam logic [7:0]  KANA_LO    = 8'ha0;
  localparam logic [7:0]  KANA_HI    = 8'hdf;
  localparam logic [7:0]  KANA_OFF   = 8'h40;

  // transfer counts: last beat index of a byte
  localparam logic [2:0]  PAR_LAST   = 3'h1;
  localparam logic [2:0]  SER_LAST   = 3'h7;
  localparam logic [2:0]  MSB_IDX    = 3'h7;

  // register map, byte offsets
  localparam logic [11:0] REG_STATUS   = 12'h000;
  localparam logic [11:0] REG_LAST_CMD = 12'h004;
  localparam logic [11:0] REG_CTRL     = 12'h008;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;

  // address counter update, wraps in six bits
  function automatic logic [5:0] step_addr(input logic [5:0] a, input logic [1:0] s,
                                           input logic [5:0] d);
    case (s)
      STEP_INC: return a + d;
      STEP_DEC: return a - d;
      default:  return a;
    endcase
  endfunction : step_addr

endpackage : lhd_pkg

// ### hw/lhd_top.sv
// Purpose: host serial / 4-bit parallel port and data path of an lcd controller
// Assumes: link pins asynchronous to hclk, strobe far slower than hclk
// Notes:   character patterns come from the CHAR_ROM parameter image
//
// Operation
// - high device reset beats every operation
// - reset release samples interface select level
// - reset leaves write mode active
// - input modes shift data on rising edges
// - read mode drives data on falling edges
// - command bytes go to the decoder
// - write mode stores data byte unchanged
// - and/or modes merge byte with memory
// - character mode writes five seven-bit columns
// - read data driven only in read mode
// - entering read mode preloads the buffer
// - serial read shifts msb first
// - parallel read: upper nibble, then lower
// - each sent byte triggers next fetch
// - character generator only after char-mode command
// - rom holds 160 ascii and katakana patterns
// - character writes keep bit seven intact
// - pointer is six-bit counter plus bank
// - counter steps per mode after accesses
// - byte latched on last strobe edge
// - busy low from latch until done
// - deselected chip ignores pins, floats outputs
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module lhd_top #(
  parameter logic [lhd_pkg::ROM_DEPTH-1:0][34:0] CHAR_ROM = '0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        lcd_reset,
  input  wire logic        interface_select,
  input  wire logic        chip_select_n,
  input  wire logic        host_strobe,
  input  wire logic        command_data_select,
  input  wire logic        serial_in,
  input  wire logic [3:0]  data_in,
  output logic      [3:0]  data_out,
  output logic             data_oe,
  output logic             serial_out,
  output logic             serial_oe,
  output logic             busy_n_out,
  output logic             busy_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  lhd_pkg::lhd_pins_s pins_raw;
  lhd_pkg::lhd_pins_s pins_s1;
  lhd_pkg::lhd_pins_s pins_s2;
  lhd_pkg::lhd_pins_s pins_d;

  assign pins_raw = '{chip_select_n, host_strobe, command_data_select, serial_in,
                      data_in, lcd_reset, interface_select};

  // two flops, then one more for edges; only s2 and d are looked at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_s1 <= lhd_pkg::PINS_RESET;
      pins_s2 <= lhd_pkg::PINS_RESET;
      pins_d  <= lhd_pkg::PINS_RESET;
    end else begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      pins_d  <= pins_s2;
    end
  end

  logic                 dev_rst;
  logic                 strobe_rise;
  logic                 strobe_fall;
  logic                 cs_act;
  logic                 link_en;
  logic                 iface_par;
  lhd_pkg::lhd_state_e  state;
  lhd_pkg::lhd_state_e  next_state;
  lhd_pkg::lhd_mode_e   mode;
  lhd_pkg::lhd_mode_e   next_mode;
  lhd_pkg::lhd_step_e   step;
  lhd_pkg::lhd_step_e   next_step;
  lhd_pkg::lhd_ptr_s    ptr;
  lhd_pkg::lhd_ptr_s    next_ptr;

  assign dev_rst     = pins_s2.lcd_reset;
  assign strobe_rise = pins_s2.host_strobe & ~pins_d.host_strobe;
  assign strobe_fall = ~pins_s2.host_strobe & pins_d.host_strobe;
  assign cs_act      = ~pins_s2.chip_select_n & link_en;

  // interface choice caught at the falling edge of the device reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iface_par <= 1'b0;
    end else if (pins_d.lcd_reset & ~pins_s2.lcd_reset) begin
      iface_par <= pins_s2.interface_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte assembly from the host

  logic [7:0] in_sr;
  logic [2:0] in_cnt;
  logic       in_done;
  logic       in_cd;
  logic       in_accept;
  logic [2:0] beat_last;

  assign beat_last = iface_par ? lhd_pkg::PAR_LAST : lhd_pkg::SER_LAST;
  // commands are still taken in read mode, otherwise it could never be left
  assign in_accept = cs_act & strobe_rise & (state == lhd_pkg::ST_IDLE) & ~in_done &
                     ((mode != lhd_pkg::MODE_READ) | pins_s2.command_data_select);

  // serial bits or nibbles, msb first; latch on the last rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_sr   <= 8'h00;
      in_cnt  <= 3'h0;
      in_done <= 1'b0;
      in_cd   <= 1'b0;
    end else if (dev_rst || !cs_act) begin
      in_cnt  <= 3'h0;
      in_done <= 1'b0;
    end else begin
      in_done <= in_accept && (in_cnt == beat_last);
      if (in_accept) begin
        if (iface_par) begin
          in_sr <= {in_sr[3:0], pins_s2.data};
        end else begin
          in_sr <= {in_sr[6:0], pins_s2.serial_in};
        end
        in_cnt <= (in_cnt == beat_last) ? 3'h0 : in_cnt + 3'h1;
        in_cd  <= pins_s2.command_data_select;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path toward the host

  logic [7:0] rd_buf;
  logic [2:0] out_cnt;
  logic       out_done;
  logic       out_accept;
  logic       buf_load;

  assign out_accept = cs_act & strobe_fall & (mode == lhd_pkg::MODE_READ) &
                      ~pins_s2.command_data_select & (state == lhd_pkg::ST_IDLE) & ~out_done;

  // output flops hold the beat while the buffer refills behind them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_cnt    <= 3'h0;
      out_done   <= 1'b0;
      data_out   <= 4'h0;
      serial_out <= 1'b0;
    end else if (dev_rst || !cs_act) begin
      out_cnt  <= 3'h0;
      out_done <= 1'b0;
    end else begin
      out_done <= out_accept && (out_cnt == beat_last);
      if (out_accept) begin
        serial_out <= rd_buf[lhd_pkg::MSB_IDX - out_cnt];
        data_out   <= (out_cnt == 3'h0) ? rd_buf[7:4] : rd_buf[3:0];
        out_cnt    <= (out_cnt == beat_last) ? 3'h0 : out_cnt + 3'h1;
      end
    end
  end

  // data drivers float when deselected and outside read mode; the busy driver floats only when deselected or link_en is low
  assign data_oe    = cs_act & iface_par & (mode == lhd_pkg::MODE_READ);
  assign serial_oe  = cs_act & ~iface_par & (mode == lhd_pkg::MODE_READ);
  assign busy_n_oe  = cs_act;
  assign busy_n_out = (state == lhd_pkg::ST_IDLE) & ~in_done;

  ////////////////////////////////////////////////////////////////////////////
  // display memory and character generator

  logic [7:0]  mem [0:1][0:49];
  logic [7:0]  mem_rd;
  logic        mem_we;
  logic        mem_bank;
  logic [5:0]  mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_old;
  logic [2:0]  col;
  logic [5:0]  col_addr;
  logic [7:0]  rom_idx;
  logic        rom_hit;
  logic [34:0] pattern;
  logic [7:0]  last_cmd;

  assign mem_rd   = (ptr.word_address_counter < lhd_pkg::MEM_WORDS) ?
                    mem[ptr.bank_select_flag][ptr.word_address_counter] : 8'h00;
  assign col_addr = ptr.word_address_counter + {3'h0, col};
  assign mem_old  = (col_addr < lhd_pkg::MEM_WORDS) ?
                    mem[ptr.bank_select_flag][col_addr] : 8'h00;

  // code to rom index: 20..7f then a0..df, anything else is blank
  always_comb begin
    rom_hit = 1'b0;
    rom_idx = 8'h00;
    if (in_sr >= lhd_pkg::ASCII_LO && in_sr <= lhd_pkg::ASCII_HI) begin
      rom_hit = 1'b1;
      rom_idx = in_sr - lhd_pkg::ASCII_LO;
    end else if (in_sr >= lhd_pkg::KANA_LO && in_sr <= lhd_pkg::KANA_HI) begin
      rom_hit = 1'b1;
      rom_idx = in_sr - lhd_pkg::KANA_OFF;
    end
  end
  assign pattern = rom_hit ? CHAR_ROM[rom_idx] : 35'h0;

  // addresses 32h..3fh are legal pointer values but touch nothing
  always_ff @(posedge hclk) begin
    if (mem_we && mem_addr < lhd_pkg::MEM_WORDS) begin
      mem[mem_bank][mem_addr] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decoder and processing engine

  lhd_pkg::lhd_step_e char_dir;
  assign char_dir = (mode == lhd_pkg::MODE_CHAR_R) ? lhd_pkg::STEP_INC : lhd_pkg::STEP_DEC;

  always_comb begin
    next_state = state;
    next_mode  = mode;
    next_step  = step;
    next_ptr   = ptr;
    mem_we     = 1'b0;
    mem_bank   = ptr.bank_select_flag;
    mem_addr   = ptr.word_address_counter;
    mem_wdata  = mem_rd;
    buf_load   = 1'b0;
    case (state)
      lhd_pkg::ST_IDLE: begin
        if (in_done) begin
          next_state = lhd_pkg::ST_EXEC;
        end else if (out_done) begin
          next_ptr.word_address_counter = lhd_pkg::step_addr(ptr.word_address_counter,
                                          step, lhd_pkg::UNIT_STEP);
          next_state = lhd_pkg::ST_FETCH;
        end
      end
      lhd_pkg::ST_EXEC: begin
        next_state = lhd_pkg::ST_IDLE;
        if (in_cd) begin
          // command byte
          if (in_sr[lhd_pkg::LOAD_BIT]) begin
            next_ptr = '{in_sr[lhd_pkg::BANK_BIT], in_sr[5:0]};
          end else if (in_sr[7:5] == lhd_pkg::OPC_MODE) begin
            next_mode = lhd_pkg::lhd_mode_e'(in_sr[4:2]);
            next_step = lhd_pkg::lhd_step_e'(in_sr[1:0]);
            if (next_mode == lhd_pkg::MODE_READ) begin
              next_state = lhd_pkg::ST_FETCH;
            end
          end else if (in_sr[7:5] == lhd_pkg::OPC_CURS_W ||
                       in_sr[7:5] == lhd_pkg::OPC_CURS_C) begin
            mem_we = 1'b1;
            mem_wdata[lhd_pkg::CURSOR_BIT] = (in_sr[7:5] == lhd_pkg::OPC_CURS_W);
            if (mode == lhd_pkg::MODE_CHAR_L || mode == lhd_pkg::MODE_CHAR_R) begin
              next_ptr.word_address_counter = lhd_pkg::step_addr(ptr.word_address_counter,
                                              char_dir, lhd_pkg::CHAR_STEP);
            end else begin
              next_ptr.word_address_counter = lhd_pkg::step_addr(ptr.word_address_counter,
                                              step, lhd_pkg::UNIT_STEP);
            end
          end
        end else begin
          case (mode)
            lhd_pkg::MODE_WRITE: begin
              mem_we    = 1'b1;
              mem_wdata = in_sr;
            end
            lhd_pkg::MODE_AND: begin
              mem_we    = 1'b1;
              mem_wdata = mem_rd & in_sr;
            end
            lhd_pkg::MODE_OR: begin
              mem_we    = 1'b1;
              mem_wdata = mem_rd | in_sr;
            end
            lhd_pkg::MODE_CHAR_L, lhd_pkg::MODE_CHAR_R: begin
              next_state = lhd_pkg::ST_CHAR;
            end
            default: begin
              // data bytes written in read mode are dropped
            end
          endcase
          if (mode == lhd_pkg::MODE_WRITE || mode == lhd_pkg::MODE_AND ||
              mode == lhd_pkg::MODE_OR) begin
            next_ptr.word_address_counter = lhd_pkg::step_addr(ptr.word_address_counter,
                                            step, lhd_pkg::UNIT_STEP);
          end
        end
      end
      lhd_pkg::ST_CHAR: begin
        mem_we    = 1'b1;
        mem_addr  = col_addr;
        mem_wdata = {mem_old[lhd_pkg::CURSOR_BIT],
                     pattern[col*lhd_pkg::PAT_W +: lhd_pkg::PAT_W]};
        if (col == lhd_pkg::COL_LAST) begin
          next_state = lhd_pkg::ST_IDLE;
          next_ptr.word_address_counter = lhd_pkg::step_addr(ptr.word_address_counter,
                                          char_dir, lhd_pkg::CHAR_STEP);
        end
      end
      lhd_pkg::ST_FETCH: begin
        buf_load   = 1'b1;
        next_state = lhd_pkg::ST_IDLE;
      end
      default: begin
        next_state = lhd_pkg::ST_IDLE;
      end
    endcase
  end

  // engine state; the device reset wins over anything in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= lhd_pkg::ST_IDLE;
      mode  <= lhd_pkg::MODE_WRITE;
      step  <= lhd_pkg::STEP_HOLD;
      ptr   <= '0;
    end else if (dev_rst) begin
      state <= lhd_pkg::ST_IDLE;
      mode  <= lhd_pkg::MODE_WRITE;
      step  <= lhd_pkg::STEP_HOLD;
      ptr   <= '0;
    end else begin
      state <= next_state;
      mode  <= next_mode;
      step  <= next_step;
      ptr   <= next_ptr;
    end
  end

  // column counter of a character write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      col <= 3'h0;
    end else if (dev_rst || state != lhd_pkg::ST_CHAR) begin
      col <= 3'h0;
    end else begin
      col <= col + 3'h1;
    end
  end

  // read buffer and last command seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_buf   <= 8'h00;
      last_cmd <= 8'h00;
    end else begin
      if (buf_load) begin
        rd_buf <= mem_rd;
      end
      if (state == lhd_pkg::ST_EXEC && in_cd) begin
        last_cmd <= in_sr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  logic        ph_write;
  logic [11:0] ph_addr;
  logic [31:0] ctrl;
  logic        ahb_go;

  assign ahb_go    = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign link_en   = ctrl[0];

  // address phase captured, write completes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write <= 1'b0;
      ph_addr  <= 12'h000;
      ctrl     <= lhd_pkg::CTRL_RESET;
      hrdata   <= 32'h0000_0000;
    end else begin
      ph_write <= ahb_go & hwrite;
      ph_addr  <= haddr[11:0];
      if (ph_write && ph_addr == lhd_pkg::REG_CTRL) begin
        ctrl <= {31'h0, hwdata[0]};
      end
      if (ahb_go && !hwrite) begin
        case (haddr[11:0])
          lhd_pkg::REG_STATUS:   hrdata <= {17'h0, ~busy_n_out, iface_par, mode, step,
                                            1'b0, ptr};
          lhd_pkg::REG_LAST_CMD: hrdata <= {24'h0, last_cmd};
          lhd_pkg::REG_CTRL:     hrdata <= ctrl;
          default:               hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  reset_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dev_rst |=> (mode == lhd_pkg::MODE_WRITE && state == lhd_pkg::ST_IDLE))
    else $error("device reset did not restore write mode");

  iface_pick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pins_d.lcd_reset && !pins_s2.lcd_reset) |=> iface_par == $past(pins_s2.interface_select))
    else $error("interface select not caught at reset release");

  read_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (data_oe || serial_oe) |-> (mode == lhd_pkg::MODE_READ && cs_act))
    else $error("read data driven outside read mode");

  deselect_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pins_s2.chip_select_n |-> (!busy_n_oe && !data_oe && !serial_oe))
    else $error("outputs driven while deselected");

  busy_hold_a: assert property (@(posedge hclk) disable iff (!hresetn || dev_rst)
    in_done |-> !busy_n_out ##1 !busy_n_out)
    else $error("busy not low after byte latch");

  write_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == lhd_pkg::ST_EXEC && !in_cd && mode == lhd_pkg::MODE_WRITE && !dev_rst &&
     ptr.word_address_counter < lhd_pkg::MEM_WORDS)
    |=> mem[$past(ptr.bank_select_flag)][$past(ptr.word_address_counter)] == $past(in_sr))
    else $error("write mode did not store the byte");

  char_len_a: assert property (@(posedge hclk) disable iff (!hresetn || dev_rst)
    (state == lhd_pkg::ST_EXEC && !in_cd &&
     (mode == lhd_pkg::MODE_CHAR_L || mode == lhd_pkg::MODE_CHAR_R))
    |=> (state == lhd_pkg::ST_CHAR)[*5] ##1 state == lhd_pkg::ST_IDLE)
    else $error("character write not five columns");

  char_bit7_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == lhd_pkg::ST_CHAR) |->
    mem_wdata[lhd_pkg::CURSOR_BIT] == mem_old[lhd_pkg::CURSOR_BIT])
    else $error("character write touched the cursor bit");

  read_preload_a: assert property (@(posedge hclk) disable iff (!hresetn || dev_rst)
    (mode != lhd_pkg::MODE_READ ##1 mode == lhd_pkg::MODE_READ) |-> ##1 rd_buf == $past(mem_rd))
    else $error("buffer not preloaded on entering read mode");

  ptr_step_a: assert property (@(posedge hclk) disable iff (!hresetn || dev_rst)
    (state == lhd_pkg::ST_EXEC && !in_cd && mode == lhd_pkg::MODE_OR && step == lhd_pkg::STEP_INC)
    |=> ptr.word_address_counter == $past(ptr.word_address_counter) + 6'h01)
    else $error("address counter did not advance");

  next_fetch_a: assert property (@(posedge hclk) disable iff (!hresetn || dev_rst)
    out_done |-> ##[1:2] state == lhd_pkg::ST_FETCH)
    else $error("no fetch after a sent byte");

endmodule : lhd_top

// ### verification/lhd_host_model.sv
// Purpose: host cpu model on the serial / 4-bit parallel link
// Assumes: strobe idles high, 80 ns link period, par set by bench
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
module lhd_host_model (
  input  wire logic       par,
  input  wire logic [3:0] data_out,
  input  wire logic       serial_out,
  input  wire logic       busy_n_out,
  output logic            chip_select_n,
  output logic            host_strobe,
  output logic            command_data_select,
  output logic            serial_in,
  output logic      [3:0] data_in
);
  initial begin
    chip_select_n = 1'b1;
    host_strobe = 1'b1;
    command_data_select = 1'b0;
    serial_in = 1'b0;
    data_in = 4'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // one byte; read beats sampled late in the high phase, where they stand
  task automatic xfer(input logic cd, input logic [7:0] wb, output logic [7:0] rb);
    int n;
    int k;
    n = par ? 2 : 8;
    #3;
    chip_select_n = 1'b0;
    command_data_select = cd;
    #40;
    for (k = 0; k < n; k++) begin
      host_strobe = 1'b0;
      data_in = wb[7-4*(k%2) -: 4];
      serial_in = wb[7-k];
      #40;
      host_strobe = 1'b1;
      #40;
      rb = par ? {rb[3:0], data_out} : {rb[6:0], serial_out};
    end
    #80;
    // wait for busy to clear before the next byte, giving up after 100 polls of 8 ns
    for (k = 0; k < 100 && busy_n_out !== 1'b1; k++) #8;
    chip_select_n = 1'b1;
    data_in = ~data_in;
    serial_in = ~serial_in;
    #40;
  endtask : xfer
endmodule : lhd_host_model

// ### verification/lhd_top_tb.sv
// Purpose: self-checking bench of the lcd host data interface
// Assumes: zero-wait slave, one rom pattern loaded for code 41h
// Notes:   both link modes run the same write / merge / read sequence
`timescale 1ns/1ps
module lhd_top_tb;
  localparam logic [34:0] PAT = 35'h5_5aa5_3c71;
  localparam logic [159:0][34:0] ROM = {4410'h0, PAT, 1155'h0};
  logic        hclk = 0, hresetn = 0, hwrite = 0, lcd_reset = 1, interface_select = 0;
  logic        par = 0, hreadyout, hresp, data_oe, serial_out, serial_oe;
  logic        chip_select_n, host_strobe, command_data_select, serial_in, busy_n_out, busy_n_oe;
  logic [1:0]  htrans = 0;
  logic [3:0]  data_in, data_out;
  logic [7:0]  rb;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  int          errors = 0, samples_checked = 0, i;
  always #4 hclk = ~hclk;
  lhd_top #(.CHAR_ROM(ROM)) lhd_top_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lcd_reset,
    .interface_select, .chip_select_n, .host_strobe, .command_data_select, .serial_in,
    .data_in, .data_out, .data_oe, .serial_out, .serial_oe, .busy_n_out, .busy_n_oe);
  lhd_host_model lhd_host_model_i (.par, .data_out, .serial_out, .busy_n_out, .chip_select_n,
    .host_strobe, .command_data_select, .serial_in, .data_in);
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // single word transfer; read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic x(input logic cd, input logic [7:0] wb);
    lhd_host_model_i.xfer(cd, wb, rb);
  endtask : x
  // select level held across the release, then flipped to prove it was latched
  task automatic lreset(input logic p);
    @(posedge hclk);
    lcd_reset <= 1'b1;
    interface_select <= p;
    par <= p;
    repeat (6) @(posedge hclk);
    lcd_reset <= 1'b0;
    repeat (6) @(posedge hclk);
    interface_select <= ~p;
    ahb(0, 32'h0, 0);
    chk("iface", rd[13], p);
    chk("mode", rd[12:10], 3'h0);
  endtask : lreset
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    #600000;
    errors++;
    end_sim();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, 32'h8, 0);
    chk("ctrl", rd, 32'h1);
    chk("ready_resp", {hreadyout, hresp}, 2'h2);
    ahb(1, 32'h8, 0);
    ahb(0, 32'h8, 0);
    chk("ctrl0", rd, 32'h0);
    ahb(1, 32'h8, 1);
    ahb(0, 32'h40, 0);
    chk("unmapped", rd, 32'h0);
    for (i = 0; i < 2; i++) begin
      lreset(i[0]);
      x(1, 8'hc5);
      ahb(0, 32'h0, 0);
      chk("load", rd[6:0], 7'h45);
      x(1, 8'h80);
      x(1, 8'h01);
      x(0, 8'ha5);
      x(0, 8'h3c);
      chk("oe", {data_oe, serial_oe, busy_n_oe}, 3'h0);
      ahb(0, 32'h0, 0);
      chk("ptr", rd[5:0], 6'h02);
      x(1, 8'h80);
      x(1, 8'h05);
      x(0, 8'h0f);
      x(1, 8'h09);
      x(0, 8'h41);
      x(1, 8'h80);
      x(1, 8'h0d);
      x(0, 8'h00);
      chk("and", rb, 8'h05);
      x(0, 8'h00);
      chk("or", rb, 8'h7d);
    end
    // bit 7 preset in 0..4, cleared in 5..9, then two characters on top
    x(1, 8'h80);
    x(1, 8'h01);
    for (i = 0; i < 10; i++) x(0, i < 5 ? 8'hff : 8'h00);
    x(1, 8'h80);
    x(1, 8'h14);
    x(0, 8'h41);
    x(0, 8'h10);
    x(1, 8'h80);
    x(1, 8'h0d);
    for (i = 0; i < 10; i++) begin
      x(0, 8'h00);
      chk("char", rb, i < 5 ? {1'b1, 7'(PAT >> 7*i)} : 8'h00);
    end
    end_sim();
  end
endmodule : lhd_top_tb
